// ---- verilog/frame_align_defs.svh ----
// Constants for the per-bus receive frame alignment supervisor
`ifndef FRAME_ALIGN_DEFS_SVH
`define FRAME_ALIGN_DEFS_SVH

// Framing and jam octets
`define FA_A1_CODE 8'hF6
`define FA_A2_CODE 8'h28
`define FA_JAM_OCTET 8'hCC

// Row layout: two framing octets, row identifier, overhead octet, slot
`define FA_ROW_LEN 6'h39
`define FA_COL_A1 6'h00
`define FA_COL_A2 6'h01
`define FA_COL_POI 6'h02
`define FA_COL_OVH 6'h03
`define FA_COL_W 6

// Row identifier octet fields
`define FA_POI_ROW_MSB 7
`define FA_POI_ROW_LSB 2
`define FA_POI_RSV_BIT 1
`define FA_ROW_W 6
`define FA_ROWS 12

// Rows carrying the overhead octets handled here
`define FA_ROW_G1 6'h03
`define FA_ROW_M2 6'h02
`define FA_ROW_M1 6'h01
`define FA_LSS_MSB 2
`define FA_LSS_LSB 0

// Link status codes
`define FA_LSS_CONN 3'h0
`define FA_LSS_DOWN 3'h3
`define FA_LSS_UP 3'h6

// Timing
`define FA_CLK_MHZ 20
`define FA_TMR_US 1000
`define FA_JAM_US 12
`define FA_TMR_W 20
`define FA_JAM_W 8

`endif

// ---- verilog/frame_align_pkg.sv ----
// Types shared by the frame alignment supervisor and its link-side framer
`include "frame_align_defs.svh"

package frame_align_pkg;

   typedef enum logic [1:0] {
      loss_of_frame_state = 2'h0,
      in_frame_state = 2'h1,
      out_of_frame_state = 2'h3,
      out_of_frame_jam_state = 2'h2
   } fsm_state_type;

   typedef struct packed {
      logic a1_ok;
      logic a2_ok;
      logic poi_ok;
      logic poi_seq;
      logic [`FA_ROW_W-1:0] row;
      logic [7:0] ovh;
   } row_report_type;

   typedef struct packed {
      fsm_state_type state;
      logic tmr_run;
      logic [`FA_TMR_W-1:0] tmr_cnt;
      logic [`FA_JAM_W-1:0] jam_cnt;
      logic tgl_seen;
      logic prev_good;
      logic prev_bad;
      logic mgmt_ok;
      logic [2:0] rx_code;
      logic link_up;
      logic [2:0] lss_tx;
      logic same_bus_down;
      logic tx_jam;
      logic tx_start;
      logic payload_ok;
      logic [7:0] mgmt_octet;
      logic mgmt_strobe;
      logic mgmt_valid;
      logic mgmt_high;
   } sup_state_type;

endpackage

// ---- verilog/bit_sync.sv ----
// Two-flop level synchroniser for a bundle of independent bits
`timescale 1ns/1ns

module bit_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_state_type;

   sync_state_type state_reg;
   sync_state_type state_next;

   generate
      if (WIDTH < 1) begin : g_chk
         $error("bit_sync WIDTH must be at least 1");
      end
   endgenerate

   // The first stage feeds only the second stage
   always_comb begin
      state_next.meta = async_i;
      state_next.stable = state_reg.meta;
      if (rst_i) begin
         state_next = '0;
      end
   end

   always_ff @(posedge clk_i) begin
      state_reg <= state_next;
   end

   assign sync_o = state_reg.stable;

endmodule

// ---- verilog/row_framer.sv ----
// Link-side octet framer: hunts the framing pair, checks row identifiers, reports each row
`timescale 1ns/1ns
`include "frame_align_defs.svh"

module row_framer #(
   parameter int ROWS = `FA_ROWS
) (
   input wire logic clk_link_i,
   input wire logic rst_link_i,
   input wire logic [7:0] octet_i,
   input wire logic octet_valid_i,
   output frame_align_pkg::row_report_type report_o,
   output logic report_tgl_o,
   output logic jam_octet_o
);

   typedef struct packed {
      logic locked;
      logic prev_a1;
      logic [`FA_COL_W-1:0] col;
      logic a1_ok;
      logic a2_ok;
      logic poi_ok;
      logic poi_seq;
      logic have_row;
      logic [`FA_ROW_W-1:0] last_row;
      frame_align_pkg::row_report_type report;
      logic tgl;
      logic jam;
   } framer_state_type;

   localparam logic [`FA_ROW_W-1:0] LAST_ROW = `FA_ROW_W'(ROWS - 1);

   framer_state_type state_reg;
   framer_state_type state_next;
   logic [`FA_ROW_W-1:0] row_num;
   logic [`FA_ROW_W-1:0] want_row;
   logic poi_valid;

   generate
      if (ROWS < 2 || ROWS > 63) begin : g_chk
         $error("row_framer ROWS out of range");
      end
   endgenerate

   assign row_num = octet_i[`FA_POI_ROW_MSB:`FA_POI_ROW_LSB];
   // Rows count down and wrap from row zero to the top row
   assign want_row = (state_reg.last_row == '0) ? LAST_ROW : state_reg.last_row - 1'b1;
   assign poi_valid = !octet_i[`FA_POI_RSV_BIT] && (^octet_i) && (row_num <= LAST_ROW);

   always_comb begin
      state_next = state_reg;
      if (octet_valid_i) begin
         state_next.jam = (octet_i == `FA_JAM_OCTET);
         if (!state_reg.locked) begin
            state_next.prev_a1 = (octet_i == `FA_A1_CODE);
            if (state_reg.prev_a1 && octet_i == `FA_A2_CODE) begin
               state_next.locked = 1'b1;
               state_next.a1_ok = 1'b1;
               state_next.a2_ok = 1'b1;
               state_next.col = `FA_COL_POI;
            end
         end else begin
            state_next.col = (state_reg.col == `FA_ROW_LEN - 1'b1) ? '0 : state_reg.col + 1'b1;
            case (state_reg.col)
               `FA_COL_A1: begin
                  state_next.a1_ok = (octet_i == `FA_A1_CODE);
               end
               `FA_COL_A2: begin
                  state_next.a2_ok = (octet_i == `FA_A2_CODE);
               end
               `FA_COL_POI: begin
                  state_next.poi_ok = poi_valid;
                  state_next.poi_seq = poi_valid && state_reg.have_row && row_num == want_row;
                  if (poi_valid) begin
                     state_next.last_row = row_num;
                     state_next.have_row = 1'b1;
                  end
               end
               `FA_COL_OVH: begin
                  state_next.report.a1_ok = state_reg.a1_ok;
                  state_next.report.a2_ok = state_reg.a2_ok;
                  state_next.report.poi_ok = state_reg.poi_ok;
                  state_next.report.poi_seq = state_reg.poi_seq;
                  state_next.report.row = state_reg.last_row;
                  state_next.report.ovh = octet_i;
                  state_next.tgl = !state_reg.tgl;
                  // A fully errored pair means the row grid is lost, so hunt again
                  if (!state_reg.a1_ok && !state_reg.a2_ok) begin
                     state_next.locked = 1'b0;
                     state_next.prev_a1 = 1'b0;
                  end
               end
               default: begin
                  state_next.col = state_next.col;
               end
            endcase
         end
      end
      if (rst_link_i) begin
         state_next = '0;
      end
   end

   always_ff @(posedge clk_link_i) begin
      state_reg <= state_next;
   end

   assign report_o = state_reg.report;
   assign report_tgl_o = state_reg.tgl;
   assign jam_octet_o = state_reg.jam;

endmodule

// ---- verilog/plcp_frame_alignment_fsm.sv ----
// Per-bus receive frame alignment supervisor with link status and transmit selection
//
// Overview of operation
// - One supervisor per bus, four states, loss-of-frame after reset
// - Entering out-of-frame starts recovery timer and jam unless head role
// - Octets delivered upward are invalid in both out-of-frame states
// - Two good sequential rows in out-of-frame give in-frame, timer stopped
// - Timer expiry in either out-of-frame state gives loss-of-frame
// - Jam seen 12 us in out-of-frame gives jam state, timer restarted
// - Jam state keeps sending jam, framed signal when head role set
// - One good row in jam state gives in-frame, timer stopped
// - Entering loss-of-frame sends far-link-down unless jam is detected, and reports link down
// - Loss-of-frame sends framed signal if head eligible, else jam
// - Two good sequential rows in loss-of-frame give in-frame, link up
// - Entering in-frame restarts transmission with the framing pair
// - Management octets invalid after in-frame until first row identifier seen
// - Both framing octets errored or two bad identifiers give out-of-frame
// - In-frame link state and outgoing code follow the incoming code
// - Out-of-frame keeps state, sends up; loss-of-frame code depends on jam
// - Forced down reports down and sends far-link-down regardless
// - Not head eligible and far-link-down received: same code sent back
// - Transmit jam or framed signal per state, head role and eligibility
// - Recovery timer runs one millisecond
// - Jam is repeating 1100 in the payload
// - Three-bit link codes; unknown incoming codes ignored
`timescale 1ns/1ns
`include "frame_align_defs.svh"

module plcp_frame_alignment_fsm #(
   parameter int ROWS = `FA_ROWS,
   parameter int TIMER_CYCLES = `FA_TMR_US * `FA_CLK_MHZ,
   parameter int JAM_CYCLES = `FA_JAM_US * `FA_CLK_MHZ
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic clk_link_i,
   input wire logic [7:0] rx_octet_i,
   input wire logic rx_octet_valid_i,
   input wire logic head_role_this_bus_i,
   input wire logic head_eligible_flag_i,
   input wire logic forced_down_control_i,
   output frame_align_pkg::fsm_state_type state_o,
   output logic link_up_o,
   output logic [2:0] lss_tx_o,
   output logic lss_same_bus_down_o,
   output logic tx_jam_o,
   output logic tx_frame_start_o,
   output logic payload_valid_o,
   output logic [7:0] mgmt_octet_o,
   output logic mgmt_strobe_o,
   output logic mgmt_valid_o,
   output logic mgmt_high_o,
   output logic jam_detected_o
);

   localparam logic [`FA_TMR_W-1:0] TMR_LAST = `FA_TMR_W'(TIMER_CYCLES - 1);
   localparam logic [`FA_JAM_W-1:0] JAM_FULL = `FA_JAM_W'(JAM_CYCLES);
   localparam logic [`FA_ROW_W-1:0] FIRST_ROW = `FA_ROW_W'(ROWS - 1);

   frame_align_pkg::sup_state_type state_reg;
   frame_align_pkg::sup_state_type state_next;
   frame_align_pkg::row_report_type rpt;
   logic rst_link;
   logic rpt_tgl_link;
   logic jam_link;
   logic [1:0] synced;
   logic ev;
   logic one_row;
   logic two_rows;
   logic pair_bad;
   logic poi_bad;
   logic jam_det;
   logic tmr_expired;
   logic code_known;

   generate
      if (TIMER_CYCLES < 2 || TIMER_CYCLES >= (1 << `FA_TMR_W)) begin : g_chk_tmr
         $error("TIMER_CYCLES out of range");
      end
      if (JAM_CYCLES < 1 || JAM_CYCLES >= (1 << `FA_JAM_W)) begin : g_chk_jam
         $error("JAM_CYCLES out of range");
      end
   endgenerate

   // Link-side reset follows the system reset; the link clock must tick for it to land
   bit_sync #(
      .WIDTH(1)
   ) u_rst_sync (
      .clk_i(clk_link_i),
      .rst_i(1'b0),
      .async_i(rst_i),
      .sync_o(rst_link)
   );

   row_framer #(
      .ROWS(ROWS)
   ) u_framer (
      .clk_link_i(clk_link_i),
      .rst_link_i(rst_link),
      .octet_i(rx_octet_i),
      .octet_valid_i(rx_octet_valid_i),
      .report_o(rpt),
      .report_tgl_o(rpt_tgl_link),
      .jam_octet_o(jam_link)
   );

   // Report word is held a whole row after its toggle, so it is stable when the toggle arrives
   bit_sync #(
      .WIDTH(2)
   ) u_evt_sync (
      .clk_i(clk_sys_i),
      .rst_i(rst_i),
      .async_i({rpt_tgl_link, jam_link}),
      .sync_o(synced)
   );

   assign ev = synced[1] != state_reg.tgl_seen;
   assign one_row = rpt.a1_ok && rpt.a2_ok && rpt.poi_ok;
   assign two_rows = one_row && rpt.poi_seq && state_reg.prev_good;
   assign pair_bad = !rpt.a1_ok && !rpt.a2_ok;
   assign poi_bad = !rpt.poi_ok || !rpt.poi_seq;
   assign jam_det = state_reg.jam_cnt == JAM_FULL;
   assign tmr_expired = state_reg.tmr_run && state_reg.tmr_cnt == TMR_LAST;
   assign code_known = rpt.ovh[`FA_LSS_MSB:`FA_LSS_LSB] == `FA_LSS_CONN
      || rpt.ovh[`FA_LSS_MSB:`FA_LSS_LSB] == `FA_LSS_DOWN
      || rpt.ovh[`FA_LSS_MSB:`FA_LSS_LSB] == `FA_LSS_UP;

   always_comb begin
      state_next = state_reg;
      state_next.tgl_seen = synced[1];
      state_next.tx_start = 1'b0;
      state_next.mgmt_strobe = 1'b0;

      // Only an unbroken run of jam counts toward detection
      if (!synced[0]) begin
         state_next.jam_cnt = '0;
      end else if (!jam_det) begin
         state_next.jam_cnt = state_reg.jam_cnt + 1'b1;
      end

      if (state_reg.tmr_run) begin
         state_next.tmr_cnt = state_reg.tmr_cnt + 1'b1;
      end

      if (ev) begin
         state_next.prev_good = one_row;
         state_next.prev_bad = poi_bad;
         if (rpt.poi_ok && rpt.row == `FA_ROW_G1 && code_known) begin
            state_next.rx_code = rpt.ovh[`FA_LSS_MSB:`FA_LSS_LSB];
         end
      end

      case (state_reg.state)
         frame_align_pkg::loss_of_frame_state: begin
            if (ev && two_rows) begin
               state_next.state = frame_align_pkg::in_frame_state;
               state_next.link_up = 1'b1;
               state_next.mgmt_ok = 1'b0;
               state_next.tx_start = 1'b1;
            end
         end
         frame_align_pkg::in_frame_state: begin
            if (ev && (pair_bad || (poi_bad && state_reg.prev_bad))) begin
               state_next.state = frame_align_pkg::out_of_frame_state;
               state_next.tmr_run = 1'b1;
               state_next.tmr_cnt = '0;
            end else begin
               if (ev && rpt.poi_ok && rpt.row == FIRST_ROW) begin
                  state_next.mgmt_ok = 1'b1;
               end
               if (state_next.rx_code == `FA_LSS_DOWN) begin
                  state_next.link_up = 1'b0;
               end else begin
                  state_next.link_up = 1'b1;
               end
            end
         end
         frame_align_pkg::out_of_frame_state: begin
            // Valid framing wins over expiry and jam in the same cycle
            if (ev && two_rows) begin
               state_next.state = frame_align_pkg::in_frame_state;
               state_next.tmr_run = 1'b0;
               state_next.tmr_cnt = '0;
               state_next.mgmt_ok = 1'b0;
               state_next.tx_start = 1'b1;
            end else if (tmr_expired) begin
               state_next.state = frame_align_pkg::loss_of_frame_state;
               state_next.tmr_run = 1'b0;
               state_next.tmr_cnt = '0;
               state_next.link_up = 1'b0;
               state_next.tx_start = head_eligible_flag_i;
            end else if (jam_det) begin
               state_next.state = frame_align_pkg::out_of_frame_jam_state;
               state_next.tmr_cnt = '0;
               state_next.tmr_run = 1'b1;
            end
         end
         frame_align_pkg::out_of_frame_jam_state: begin
            if (ev && one_row) begin
               state_next.state = frame_align_pkg::in_frame_state;
               state_next.tmr_run = 1'b0;
               state_next.tmr_cnt = '0;
               state_next.mgmt_ok = 1'b0;
               state_next.tx_start = 1'b1;
            end else if (tmr_expired) begin
               state_next.state = frame_align_pkg::loss_of_frame_state;
               state_next.tmr_run = 1'b0;
               state_next.tmr_cnt = '0;
               state_next.link_up = 1'b0;
               state_next.tx_start = head_eligible_flag_i;
            end
         end
         default: begin
            state_next.state = frame_align_pkg::loss_of_frame_state;
         end
      endcase

      // Outgoing link status code on the opposite bus, from the state being entered
      case (state_next.state)
         frame_align_pkg::in_frame_state: begin
            state_next.lss_tx = (state_next.rx_code == `FA_LSS_DOWN) ? `FA_LSS_UP : `FA_LSS_CONN;
         end
         frame_align_pkg::loss_of_frame_state: begin
            state_next.lss_tx = jam_det ? `FA_LSS_UP : `FA_LSS_DOWN;
            state_next.link_up = 1'b0;
         end
         default: begin
            state_next.lss_tx = `FA_LSS_UP;
         end
      endcase
      if (forced_down_control_i) begin
         state_next.lss_tx = `FA_LSS_DOWN;
         state_next.link_up = 1'b0;
      end

      // A node that cannot become head isolates itself next to a failure
      state_next.same_bus_down = !head_eligible_flag_i && state_next.rx_code == `FA_LSS_DOWN;

      case (state_next.state)
         frame_align_pkg::out_of_frame_state,
         frame_align_pkg::out_of_frame_jam_state: begin
            state_next.tx_jam = !head_role_this_bus_i;
         end
         frame_align_pkg::loss_of_frame_state: begin
            state_next.tx_jam = !head_eligible_flag_i;
         end
         default: begin
            state_next.tx_jam = 1'b0;
         end
      endcase

      state_next.payload_ok = state_next.state == frame_align_pkg::in_frame_state;
      if (ev && rpt.poi_ok && (rpt.row == `FA_ROW_M1 || rpt.row == `FA_ROW_M2)) begin
         state_next.mgmt_strobe = 1'b1;
         state_next.mgmt_octet = rpt.ovh;
         state_next.mgmt_high = rpt.row == `FA_ROW_M2;
         state_next.mgmt_valid = state_next.payload_ok && state_next.mgmt_ok;
      end

      if (rst_i) begin
         state_next = '0;
         state_next.state = frame_align_pkg::loss_of_frame_state;
         state_next.lss_tx = `FA_LSS_DOWN;
         state_next.tx_jam = 1'b1;
         state_next.tgl_seen = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      state_reg <= state_next;
   end

   assign state_o = state_reg.state;
   assign link_up_o = state_reg.link_up;
   assign lss_tx_o = state_reg.lss_tx;
   assign lss_same_bus_down_o = state_reg.same_bus_down;
   assign tx_jam_o = state_reg.tx_jam;
   assign tx_frame_start_o = state_reg.tx_start;
   assign payload_valid_o = state_reg.payload_ok;
   assign mgmt_octet_o = state_reg.mgmt_octet;
   assign mgmt_strobe_o = state_reg.mgmt_strobe;
   assign mgmt_valid_o = state_reg.mgmt_valid;
   assign mgmt_high_o = state_reg.mgmt_high;
   assign jam_detected_o = jam_det;

endmodule

// ---- tb/plcp_frame_alignment_fsm_properties.sv ----
// Port-level concurrent checks for the frame alignment supervisor
`timescale 1ns/1ns

module plcp_frame_alignment_fsm_properties #(
   parameter int TIMER_CYCLES = 20000
) (
   input wire logic clk_sys_i,
   input wire logic rst_i,
   input wire logic head_role_this_bus_i,
   input wire logic head_eligible_flag_i,
   input wire logic forced_down_control_i,
   input wire frame_align_pkg::fsm_state_type state_o,
   input wire logic link_up_o,
   input wire logic [2:0] lss_tx_o,
   input wire logic tx_jam_o,
   input wire logic tx_frame_start_o,
   input wire logic payload_valid_o,
   input wire logic jam_detected_o
);
   logic oof, lof, inf;
   logic [31:0] oof_cnt;
   assign lof = state_o == frame_align_pkg::loss_of_frame_state;
   assign inf = state_o == frame_align_pkg::in_frame_state;
   assign oof = !lof && !inf;
   // Restart on entry to the jam state, as the recovery timer does
   always_ff @(posedge clk_sys_i) begin
      if (rst_i || !oof || (state_o == frame_align_pkg::out_of_frame_jam_state && $past(state_o) != state_o)) begin
         oof_cnt <= 32'h0;
      end else begin
         oof_cnt <= oof_cnt + 32'h1;
      end
   end
   default clocking dcb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);
   sequence s_enter_inf;
      inf && !$past(inf) && !$past(rst_i);
   endsequence
   property p_frame_start;
      s_enter_inf |-> tx_frame_start_o ##1 !tx_frame_start_o;
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("no framing restart pulse");
   property p_lof_up;
      s_enter_inf and $past(lof) && !$past(forced_down_control_i) |-> link_up_o;
   endproperty
   a_lof_up: assert property (p_lof_up) else $error("link not up on regaining frame");
   property p_oof_invalid;
      oof |-> !payload_valid_o;
   endproperty
   a_oof_invalid: assert property (p_oof_invalid) else $error("payload valid while out of frame");
   property p_forced;
      forced_down_control_i |=> !link_up_o && lss_tx_o == 3'h3;
   endproperty
   a_forced: assert property (p_forced) else $error("forced down not obeyed");
   property p_oof_tx;
      oof && $stable(head_role_this_bus_i) && !$past(rst_i) |-> tx_jam_o == !head_role_this_bus_i;
   endproperty
   a_oof_tx: assert property (p_oof_tx) else $error("wrong transmit choice out of frame");
   property p_lof_tx;
      lof && !head_role_this_bus_i && $stable(head_role_this_bus_i) && $stable(head_eligible_flag_i) && !$past(rst_i)
         |-> tx_jam_o == !head_eligible_flag_i;
   endproperty
   a_lof_tx: assert property (p_lof_tx) else $error("wrong transmit choice in loss of frame");
   property p_lof_link;
      lof |-> !link_up_o;
   endproperty
   a_lof_link: assert property (p_lof_link) else $error("link up in loss of frame");
   property p_lof_lss;
      lof && $past(lof) && !$past(forced_down_control_i) && $stable(jam_detected_o) && !$past(rst_i)
         |-> lss_tx_o == (jam_detected_o ? 3'h6 : 3'h3);
   endproperty
   a_lof_lss: assert property (p_lof_lss) else $error("wrong code in loss of frame");
   property p_oof_lss;
      oof && $past(oof) && !$past(forced_down_control_i) && !$past(rst_i) |-> lss_tx_o == 3'h6;
   endproperty
   a_oof_lss: assert property (p_oof_lss) else $error("wrong code out of frame");
   property p_inf_lss;
      inf && $past(inf) && !$past(forced_down_control_i) && !$past(rst_i)
         |-> (link_up_o && lss_tx_o == 3'h0) || (!link_up_o && lss_tx_o == 3'h6);
   endproperty
   a_inf_lss: assert property (p_inf_lss) else $error("code and link state disagree in frame");
   property p_timer_bound;
      oof_cnt <= TIMER_CYCLES + 8;
   endproperty
   a_timer_bound: assert property (p_timer_bound) else $error("recovery timer overran");
endmodule

bind plcp_frame_alignment_fsm plcp_frame_alignment_fsm_properties #(.TIMER_CYCLES(TIMER_CYCLES))
   u_plcp_frame_alignment_fsm_properties (.clk_sys_i, .rst_i, .head_role_this_bus_i, .head_eligible_flag_i,
   .forced_down_control_i, .state_o, .link_up_o, .lss_tx_o, .tx_jam_o, .tx_frame_start_o, .payload_valid_o,
   .jam_detected_o);

// ---- tb/link_source.sv ----
// Far-end line model: framed rows, jam or a dead line on the link clock
`timescale 1ns/1ns

module link_source #(
   parameter int ROWS = 12
) (
   input wire logic clk_link_i,
   input wire logic rst_i,
   input wire logic [1:0] mode_i,
   input wire logic [2:0] lss_i,
   output logic [7:0] octet_o,
   output logic valid_o
);
   int col = 0;
   int row = ROWS - 1;
   logic [5:0] rn;
   initial begin
      octet_o = 8'h00;
      valid_o = 1'b0;
      @(negedge rst_i);
      repeat (4) @(posedge clk_link_i);
      forever begin
         #3;
         valid_o = 1'b1;
         rn = 6'(row);
         // Rows restart at the framing pair once the line is framed again
         if (mode_i != 2'h0) begin
            octet_o = (mode_i == 2'h1) ? 8'hCC : 8'h00;
            col = 0;
         end else begin
            case (col)
               0: octet_o = 8'hF6;
               1: octet_o = 8'h28;
               2: octet_o = {rn, 1'b0, ~^rn};
               3: octet_o = (row == 3) ? {5'h00, lss_i} : (row == 2 || row == 1) ? {6'h28, rn[1:0]} : 8'h00;
               default: octet_o = 8'h55;
            endcase
            col = col + 1;
            if (col == 57) begin
               col = 0;
               row = (row == 0) ? ROWS - 1 : row - 1;
            end
         end
         @(posedge clk_link_i);
      end
   end
endmodule

// ---- tb/plcp_frame_alignment_fsm_tb.sv ----
// Self-checking bench for the frame alignment supervisor
`timescale 1ns/1ns

module plcp_frame_alignment_fsm_tb;
   localparam int TMR = 200;
   localparam logic [2:0] codes [4] = '{3'h3, 3'h5, 3'h0, 3'h6};
   logic clk_sys_i = 1'b0;
   logic clk_link_i = 1'b0;
   logic rst_i = 1'b1;
   logic role = 1'b0;
   logic elig = 1'b0;
   logic forced = 1'b0;
   logic [1:0] mode = 2'h0;
   logic [2:0] lss_in = 3'h0;
   logic [7:0] octet, m_octet;
   logic [2:0] lss_tx;
   logic valid, link_up, same_down, tx_jam, tx_start, pay_ok, m_strobe, m_valid, m_high, jam_det;
   frame_align_pkg::fsm_state_type state;
   int bad_count = 0;
   int compares = 0;
   int n;
   initial begin
      forever #25 clk_sys_i = ~clk_sys_i;
   end
   // Odd start offset keeps the link clock unrelated in phase
   initial begin
      #7;
      forever #24 clk_link_i = ~clk_link_i;
   end
   link_source u_link_source (.clk_link_i(clk_link_i), .rst_i(rst_i), .mode_i(mode), .lss_i(lss_in),
      .octet_o(octet), .valid_o(valid));
   plcp_frame_alignment_fsm #(.TIMER_CYCLES(TMR), .JAM_CYCLES(20)) u_plcp_frame_alignment_fsm (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_link_i(clk_link_i), .rx_octet_i(octet), .rx_octet_valid_i(valid),
      .head_role_this_bus_i(role), .head_eligible_flag_i(elig), .forced_down_control_i(forced), .state_o(state),
      .link_up_o(link_up), .lss_tx_o(lss_tx), .lss_same_bus_down_o(same_down), .tx_jam_o(tx_jam),
      .tx_frame_start_o(tx_start), .payload_valid_o(pay_ok), .mgmt_octet_o(m_octet), .mgmt_strobe_o(m_strobe),
      .mgmt_valid_o(m_valid), .mgmt_high_o(m_high), .jam_detected_o(jam_det));
   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk_sys_i);
      #5;
   endtask
   task automatic wait_for(input frame_align_pkg::fsm_state_type s, input int bound);
      for (n = 0; n < bound && state !== s; n++) tick(1);
      check("state", 8'(s), 8'(state));
      if (state !== s) conclude();
   endtask
   task automatic wait_hi(ref logic s, input int bound);
      for (n = 0; n < bound && s !== 1'b1; n++) tick(1);
      check("wait", 8'h01, 8'(s));
      if (s !== 1'b1) conclude();
   endtask
   task automatic t_acquire();
      wait_for(frame_align_pkg::in_frame_state, 400);
      check("two_rows", 8'h01, 8'(n > 40));
      check("link_up", 8'h01, 8'(link_up));
      tick(2);
      check("pay_ok", 8'h01, 8'(pay_ok));
      check("tx_jam", 8'h00, 8'(tx_jam));
      wait_hi(m_valid, 1600);
      check("m_strobe", 8'h01, 8'(m_strobe));
      check("m_high", 8'h01, 8'(m_high));
      check("m_octet", 8'hA2, m_octet);
   endtask
   task automatic t_codes();
      for (int i = 0; i < 4; i++) begin
         lss_in = codes[i];
         tick(700);
         check("link_up", 8'(i > 1), 8'(link_up));
         check("lss_tx", i > 1 ? 8'h00 : 8'h06, 8'(lss_tx));
         check("same_down", 8'(i < 2), 8'(same_down));
      end
   endtask
   task automatic t_forced();
      forced = 1'b1;
      tick(2);
      check("link_up", 8'h00, 8'(link_up));
      check("lss_tx", 8'h03, 8'(lss_tx));
      check("state", 8'(frame_align_pkg::in_frame_state), 8'(state));
      forced = 1'b0;
      tick(2);
   endtask
   task automatic t_lose();
      mode = 2'h2;
      wait_for(frame_align_pkg::out_of_frame_state, 400);
      check("pay_ok", 8'h00, 8'(pay_ok));
      check("tx_jam", 8'h01, 8'(tx_jam));
      check("link_up", 8'h01, 8'(link_up));
      role = 1'b1;
      elig = 1'b1;
      tick(2);
      check("tx_jam", 8'h00, 8'(tx_jam));
      check("lss_tx", 8'h06, 8'(lss_tx));
      role = 1'b0;
      elig = 1'b0;
      wait_for(frame_align_pkg::loss_of_frame_state, TMR + 50);
      check("timer", 8'h01, 8'(n + 2 > TMR - 10 && n + 2 < TMR + 10));
      check("link_up", 8'h00, 8'(link_up));
      check("lss_tx", 8'h03, 8'(lss_tx));
      elig = 1'b1;
      tick(2);
      check("tx_jam", 8'h00, 8'(tx_jam));
      elig = 1'b0;
      tick(2);
   endtask
   task automatic t_jam();
      mode = 2'h1;
      wait_hi(jam_det, 200);
      check("jam_time", 8'h01, 8'(n >= 20));
      tick(2);
      check("lss_tx", 8'h06, 8'(lss_tx));
      mode = 2'h0;
      wait_for(frame_align_pkg::in_frame_state, 400);
      mode = 2'h1;
      wait_for(frame_align_pkg::out_of_frame_jam_state, 400);
      check("tx_jam", 8'h01, 8'(tx_jam));
      check("pay_ok", 8'h00, 8'(pay_ok));
      mode = 2'h0;
      wait_for(frame_align_pkg::in_frame_state, 100);
      check("one_row", 8'h01, 8'(n < 40));
   endtask
   initial begin
      repeat (12) @(posedge clk_sys_i);
      #5;
      rst_i = 1'b0;
      tick(1);
      check("state", 8'h00, 8'(state));
      check("lss_tx", 8'h03, 8'(lss_tx));
      check("tx_jam", 8'h01, 8'(tx_jam));
      t_acquire();
      t_codes();
      t_forced();
      t_lose();
      t_jam();
      conclude();
   end
endmodule
